// >>> verilog/hsl_top.sv
/*
 Top of the hub strap latch and indicator block: latches straps after
 reset, decodes them, drives the suspend indicator, senses self power,
 notes test mode, and exposes state over a plain register port.
 Assumes a 50 MHz clock, synchronous pins, and an external reset held
 low at least one microsecond.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - Latch select bit two at reset release
// - Missing select bit two reads as zero
// - Internal power-on hold before logic runs
// - Indicator asserted only when configured and active
// - Sense low means bus powered, high self
// - Sample fixed-port straps when enabled
// - Decode strap into fixed port map
// - Low strap bit sets LED polarity
// - Test input selects continuity test mode
// - Select 001 means SMBus slave, no straps
module hsl_top
#(
   parameter int STABLE_CYC = hsl_pkg::POR_STABLE_CYC,
   parameter bit HAS_SEL2 = 1'b1
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Strap pins
   input wire logic [2:0] i_cfg_sel,
   input wire logic [1:0] i_fixed_port_strap,
   input wire logic i_self_power_sense,
   input wire logic i_test,
   // Hub state
   input wire logic i_configured,
   input wire logic i_suspended,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Indicator and decoded outputs
   output logic o_suspend_indicator,
   output logic o_suspend_indicator_oe,
   output logic [3:1] o_fixed_ports,
   output logic o_self_powered,
   output logic o_test_mode,
   output logic o_smbus_mode,
   output logic [6:0] o_smbus_addr
);
   // ==========================================================
   // Strap capture and decode
   // ==========================================================
   hsl_strap_if strap ();
   logic [3:1] dec_ports;
   logic dec_led_low;
   logic dec_strap_en;
   logic dec_smbus;
   hsl_latch #(.STABLE_CYC(STABLE_CYC), .HAS_SEL2(HAS_SEL2)) u_latch
   (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_cfg_sel(i_cfg_sel),
      .i_strap(i_fixed_port_strap),
      .o_strap(strap)
   );
   hsl_decode u_decode
   (
      .i_strap(strap),
      .o_fixed_ports(dec_ports),
      .o_led_active_low(dec_led_low),
      .o_strap_en(dec_strap_en),
      .o_smbus_mode(dec_smbus)
   );
   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed
   {
      logic [1:0] control;
      logic [31:0] rdata;
      logic ind;
      logic ind_oe;
      logic [3:1] ports;
      logic self_pwr;
      logic test;
      logic smbus;
   } hsl_top_s;
   hsl_top_s st;
   hsl_top_s next_st;
   logic active;
   logic [31:0] status_word;
   assign active = st.control[hsl_pkg::CT_CONFIGURED] &
      ~st.control[hsl_pkg::CT_SUSPENDED];
   always_comb
   begin
      status_word = 32'h0;
      status_word[hsl_pkg::ST_CFG_LSB +: 3] = strap.cfg_sel;
      status_word[hsl_pkg::ST_STRAP_EN] = dec_strap_en;
      status_word[hsl_pkg::ST_SMBUS] = dec_smbus;
      status_word[hsl_pkg::ST_LED_LOW] = dec_led_low;
      status_word[hsl_pkg::ST_SELF_PWR] = st.self_pwr;
      status_word[hsl_pkg::ST_TEST] = st.test;
      status_word[hsl_pkg::ST_LATCHED] = strap.latched;
   end
   always_comb
   begin
      next_st = st;
      next_st.rdata = 32'h0;
      // Hub state pins reload the control register every cycle; a write ORs its
      // data with the pins, so a software report lasts for one cycle only.
      next_st.control[hsl_pkg::CT_CONFIGURED] = i_configured;
      next_st.control[hsl_pkg::CT_SUSPENDED] = i_suspended;
      if (i_wr && i_addr == hsl_pkg::ADDR_CONTROL)
      begin
         next_st.control = i_wdata[1:0] | {i_suspended, i_configured};
      end
      if (i_rd)
      begin
         case (i_addr)
            hsl_pkg::ADDR_STATUS: next_st.rdata = status_word;
            hsl_pkg::ADDR_CONTROL: next_st.rdata = {30'h0, st.control};
            hsl_pkg::ADDR_PORTMAP: next_st.rdata = {28'h0, st.ports, 1'b0};
            hsl_pkg::ADDR_ID: next_st.rdata = {16'h0, hsl_pkg::ID_VALUE};
            default: next_st.rdata = 32'h0;
         endcase
      end
      // The shared pin only drives once straps have been sampled.
      next_st.ind_oe = strap.latched;
      next_st.ind = strap.latched & (active ^ dec_led_low);
      next_st.ports = dec_ports;
      next_st.self_pwr = strap.latched ? st.self_pwr :
         i_self_power_sense;
      next_st.test = i_test;
      next_st.smbus = dec_smbus;
   end
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         st <= '0;
      else
         st <= next_st;
   end
   assign o_rdata = st.rdata;
   assign o_suspend_indicator = st.ind;
   assign o_suspend_indicator_oe = st.ind_oe;
   assign o_fixed_ports = st.ports;
   assign o_self_powered = st.self_pwr;
   assign o_test_mode = st.test;
   assign o_smbus_mode = st.smbus;
   assign o_smbus_addr = hsl_pkg::SMBUS_ADDR;
endmodule // hsl_top

// >>> verilog/hsl_pkg.sv
/*
 Shared constants for the hub strap latch block: register map, field
 positions, reset values, configuration-select codes and timing counts.
 Assumes a 50 MHz system clock and a plain single-cycle register port.
*/
package hsl_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_HZ = 50_000_000;
   localparam int RESET_MIN_NS = 1000;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS * (CLK_HZ / 1_000_000)
      + 999) / 1000;
   localparam int POR_STABLE_CYC = 64;
   localparam int REF_CLOCK_HZ = 24_000_000;
   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_PORTMAP = 4'h8;
   localparam logic [3:0] ADDR_ID = 4'hc;
   // Status fields.
   localparam int ST_CFG_LSB = 0;
   localparam int ST_STRAP_EN = 3;
   localparam int ST_SMBUS = 4;
   localparam int ST_LED_LOW = 5;
   localparam int ST_SELF_PWR = 6;
   localparam int ST_TEST = 7;
   localparam int ST_LATCHED = 8;
   // Control fields.
   localparam int CT_CONFIGURED = 0;
   localparam int CT_SUSPENDED = 1;
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   // Configuration-select codes.
   localparam logic [2:0] CFG_DEFAULT = 3'h0;
   localparam logic [2:0] CFG_SMBUS = 3'h1;
   localparam logic [2:0] CFG_BUSPWR = 3'h2;
   localparam logic [6:0] SMBUS_ADDR = 7'h2c;
   // Arbitrary identification value.
   localparam logic [15:0] ID_VALUE = 16'ha5c3;
   typedef enum logic [1:0]
   {
      HSL_RESET = 2'b00,
      HSL_WAIT = 2'b01,
      HSL_RUN = 2'b11
   } hsl_phase_e;
endpackage

// >>> verilog/hsl_if.sv
/*
 Interface carrying latched strap values from the latch to the decoder.
 Assumes both ends share i_clk.
*/
`timescale 1ns/1ps
interface hsl_strap_if;
   logic [2:0] cfg_sel;
   logic [1:0] fixed_port_strap;
   logic latched;
   modport src (output cfg_sel, output fixed_port_strap, output latched);
   modport dst (input cfg_sel, input fixed_port_strap, input latched);
endinterface

// >>> verilog/hsl_latch.sv
/*
 Captures the configuration-select and fixed-port strap pins once, at
 the end of the power-on stable wait after reset release.
 Assumes pins are synchronous to i_clk.
*/
`timescale 1ns/1ps
module hsl_latch
#(
   parameter int STABLE_CYC = hsl_pkg::POR_STABLE_CYC,
   parameter bit HAS_SEL2 = 1'b1
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Pins
   input wire logic [2:0] i_cfg_sel,
   input wire logic [1:0] i_strap,
   // Latched values
   hsl_strap_if.src o_strap
);
   // The wait counter is sixteen bits wide, so longer waits are refused.
   if (STABLE_CYC < 1 || STABLE_CYC > 65535)
   begin : g_bad_stable
      $error("STABLE_CYC out of range");
   end
   typedef struct packed
   {
      hsl_pkg::hsl_phase_e phase;
      logic [15:0] cnt;
      logic [2:0] cfg;
      logic [1:0] strap;
   } hsl_latch_s;
   hsl_latch_s st;
   hsl_latch_s next_st;
   always_comb
   begin
      next_st = st;
      case (st.phase)
         hsl_pkg::HSL_RESET:
         begin
            next_st.phase = hsl_pkg::HSL_WAIT;
            next_st.cnt = 16'h0;
         end
         hsl_pkg::HSL_WAIT:
         begin
            // Holding off until supplies settle stands in for the POR.
            if (st.cnt == 16'(STABLE_CYC - 1))
            begin
               next_st.phase = hsl_pkg::HSL_RUN;
               next_st.cfg = i_cfg_sel;
               if (!HAS_SEL2)
                  next_st.cfg[2] = 1'b0;
               next_st.strap = i_strap;
            end
            else
               next_st.cnt = st.cnt + 16'h1;
         end
         hsl_pkg::HSL_RUN:
            next_st = st;
         default:
            next_st.phase = hsl_pkg::HSL_RESET;
      endcase
   end
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         st <= '0;
      else
         st <= next_st;
   end
   assign o_strap.cfg_sel = st.cfg;
   assign o_strap.fixed_port_strap = st.strap;
   assign o_strap.latched = (st.phase == hsl_pkg::HSL_RUN);
endmodule // hsl_latch

// >>> verilog/hsl_decode.sv
/*
 Decodes latched straps into port map, LED polarity and mode flags.
 Assumes latched values are stable once latched is high.
*/
`timescale 1ns/1ps
module hsl_decode
(
   // Latched values
   hsl_strap_if.dst i_strap,
   // Decoded
   output logic [3:1] o_fixed_ports,
   output logic o_led_active_low,
   output logic o_strap_en,
   output logic o_smbus_mode
);
   function automatic logic [3:1] hsl_port_map(input logic [1:0] s);
      case (s)
         2'h1: hsl_port_map = 3'h1;
         2'h2: hsl_port_map = 3'h3;
         2'h3: hsl_port_map = 3'h7;
         default: hsl_port_map = 3'h0;
      endcase
   endfunction
   logic strap_en;
   // Register-driven modes ignore the strap pins.
   assign strap_en = (i_strap.cfg_sel == hsl_pkg::CFG_DEFAULT) ||
      (i_strap.cfg_sel == hsl_pkg::CFG_BUSPWR);
   assign o_strap_en = strap_en;
   assign o_smbus_mode = (i_strap.cfg_sel == hsl_pkg::CFG_SMBUS);
   assign o_fixed_ports = strap_en ?
      hsl_port_map(i_strap.fixed_port_strap) : 3'h0;
   assign o_led_active_low = strap_en & i_strap.fixed_port_strap[0];
endmodule // hsl_decode

// >>> verif/hsl_props.sv
/* Checker on the hsl_top ports.
 Assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
// ====
// Checker
module hsl_props
#(parameter int STABLE_CYC = hsl_pkg::POR_STABLE_CYC)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Inputs
   input wire logic i_configured,
   input wire logic i_suspended,
   input wire logic i_wr,
   input wire logic i_self_power_sense,
   // Outputs
   input wire logic o_suspend_indicator,
   input wire logic o_suspend_indicator_oe,
   input wire logic [3:1] o_fixed_ports,
   input wire logic o_self_powered,
   input wire logic o_smbus_mode,
   input wire logic [6:0] o_smbus_addr
);
   logic [15:0] cnt;
   // Counts edges since reset release, saturating.
   always_ff @(posedge i_clk or negedge i_resetn)
      if (!i_resetn)
         cnt <= 16'h0;
      else if (cnt != 16'hffff)
         cnt <= cnt + 16'h1;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence s_run;
      o_suspend_indicator_oe ##1 o_suspend_indicator_oe;
   endsequence
   a_por_hold: assert property (cnt < STABLE_CYC |->
      !o_suspend_indicator_oe) else $error("latched too early");
   a_latch_due: assert property (cnt > STABLE_CYC + 2 |->
      o_suspend_indicator_oe) else $error("latch late");
   a_straps_hold: assert property (s_run |->
      $stable(o_fixed_ports) && $stable(o_smbus_mode)) else $error("moved");
   a_power_hold: assert property (s_run |->
      $stable(o_self_powered)) else $error("power moved");
   a_power_sense: assert property (cnt >= 1 && cnt < STABLE_CYC |->
      o_self_powered == $past(i_self_power_sense)) else $error("sense");
   a_port_code: assert property (
      o_fixed_ports inside {3'h0, 3'h1, 3'h3, 3'h7}) else $error("ports");
   a_smbus_only: assert property (o_smbus_mode |->
      o_fixed_ports == 3'h0 && o_smbus_addr == 7'h2c) else $error("smbus");
   // Hub state passes the control flop and then the indicator flop.
   a_ind_level: assert property (s_run ##0 (!$past(i_wr) &&
      !$past(i_wr, 2)) |-> o_suspend_indicator ==
      (($past(i_configured, 2) && !$past(i_suspended, 2)) ^
      (^o_fixed_ports))) else $error("indicator");
endmodule // hsl_props
bind hsl_top hsl_props #(.STABLE_CYC(STABLE_CYC)) u_hsl_props(
   .i_clk(i_clk), .i_resetn(i_resetn), .i_configured(i_configured),
   .i_suspended(i_suspended), .i_wr(i_wr),
   .i_self_power_sense(i_self_power_sense),
   .o_suspend_indicator(o_suspend_indicator),
   .o_suspend_indicator_oe(o_suspend_indicator_oe),
   .o_fixed_ports(o_fixed_ports), .o_self_powered(o_self_powered),
   .o_smbus_mode(o_smbus_mode), .o_smbus_addr(o_smbus_addr));

// >>> verif/hsl_board.sv
/* Board model: strap resistors, shared pins and reset source.
 Assumes the bench times the reset request. */
`timescale 1ns/1ps
// ====
// Board
module hsl_board
(
   // Clock and requests
   input wire logic i_clk,
   input wire logic i_reset_req,
   // Strap resistor levels
   input wire logic [2:0] i_cfg,
   input wire logic [1:0] i_strap,
   input wire logic i_sense,
   // Hub drives the shared pins
   input wire logic i_oe,
   // Pins
   output logic o_resetn,
   output logic [2:0] o_cfg_pin,
   output logic [1:0] o_strap_pin,
   output logic o_sense_pin,
   // Reference clock from the crystal
   output logic o_ref_clock
);
   localparam realtime REF_HALF_NS = 500_000_000.0 / hsl_pkg::REF_CLOCK_HZ;
   // The block runs from the system clock; the crystal is still modelled
   // so the board offers the reference the hub expects.
   initial
   begin
      o_ref_clock = 1'b0;
      forever #(REF_HALF_NS) o_ref_clock = ~o_ref_clock;
   end
   logic flip = 1'b0;
   // Once driven by the hub the strap levels are gone; toggling pins
   // expose any late resampling.
   always @(posedge i_clk)
      flip <= ~flip;
   assign o_resetn = !i_reset_req;
   assign o_cfg_pin = i_oe ? i_cfg ^ {3{flip}} : i_cfg;
   assign o_strap_pin = i_oe ? i_strap ^ {2{flip}} : i_strap;
   assign o_sense_pin = i_oe ? i_sense ^ flip : i_sense;
endmodule // hsl_board

// >>> verif/hsl_top_bench.sv
/* Self-checking bench for hsl_top with the board model.
 Assumes hsl_props is bound to hsl_top. */
`timescale 1ns/1ps
// ====
// Bench
module hsl_top_bench;
   localparam int STB = 4;
   logic i_clk = 1'b0;
   logic req = 1'b1;
   logic [2:0] cfg = 3'h0;
   logic [1:0] strap = 2'h0;
   logic sense = 1'b0;
   logic i_test = 1'b0;
   logic i_configured = 1'b0;
   logic i_suspended = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic rd_q = 1'b0;
   logic i_resetn, pin_sense, oe, ind, tm, smb, spw;
   logic [2:0] pin_cfg;
   logic [1:0] pin_strap;
   logic [31:0] o_rdata;
   logic [3:1] fp;
   logic [31:0] exp_q[$];
   int failures = 0;
   int cmp_count = 0;
   initial forever #10 i_clk = ~i_clk;
   hsl_board u_hsl_board(.i_clk(i_clk), .i_reset_req(req), .i_cfg(cfg),
      .i_strap(strap), .i_sense(sense), .i_oe(oe), .o_resetn(i_resetn),
      .o_cfg_pin(pin_cfg), .o_strap_pin(pin_strap), .o_sense_pin(pin_sense),
      .o_ref_clock());
   hsl_top #(.STABLE_CYC(STB)) u_hsl_top(.i_clk(i_clk), .i_resetn(i_resetn),
      .i_cfg_sel(pin_cfg), .i_fixed_port_strap(pin_strap),
      .i_self_power_sense(pin_sense), .i_test(i_test),
      .i_configured(i_configured), .i_suspended(i_suspended),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_suspend_indicator(ind),
      .o_suspend_indicator_oe(oe), .o_fixed_ports(fp),
      .o_self_powered(spw), .o_test_mode(tm), .o_smbus_mode(smb),
      .o_smbus_addr());
   task automatic chk(input string n, input logic [31:0] e, s);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   // Leaves the strobe high so reads can run back to back.
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      @(posedge i_clk);
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge i_clk)
      rd_q <= i_rd;
   always @(negedge i_clk)
      if (rd_q)
         chk("rdata", exp_q.pop_front(), o_rdata);
   initial
   begin
      #(20 * 20000);
      failures++;
      finish_test();
   end
   initial
   begin
      logic [2:0] c;
      logic [1:0] s;
      logic en;
      logic [3:1] pm;
      logic [31:0] w;
      void'($urandom(38824));
      repeat (6) @(posedge i_clk);
      for (int k = 0; k < 32; k++)
      begin
         c = k[4:2];
         s = k[1:0];
         cfg <= c;
         strap <= s;
         sense <= 1'($urandom);
         i_test <= 1'($urandom);
         req <= 1'b1;
         repeat (hsl_pkg::RESET_MIN_CYC) @(posedge i_clk);
         req <= 1'b0;
         repeat (STB + 6) @(posedge i_clk);
         en = c == hsl_pkg::CFG_DEFAULT || c == hsl_pkg::CFG_BUSPWR;
         pm = en ? {&s, s[1], |s} : 3'h0;
         chk("ports", 32'(pm), 32'(fp));
         chk("selfpwr", 32'(sense), 32'(spw));
         chk("smbus", 32'(c == hsl_pkg::CFG_SMBUS), 32'(smb));
         chk("test", 32'(i_test), 32'(tm));
         rd(hsl_pkg::ADDR_STATUS, {23'h0, 1'b1, i_test, sense, en & s[0],
            c == hsl_pkg::CFG_SMBUS, en, c});
         rd(hsl_pkg::ADDR_PORTMAP, {28'h0, pm, 1'b0});
         rd(hsl_pkg::ADDR_ID, {16'h0, hsl_pkg::ID_VALUE});
         rd(4'h2, 32'h0);
         i_rd <= 1'b0;
         i_wr <= 1'b1;
         i_addr <= hsl_pkg::ADDR_CONTROL;
         w = $urandom;
         i_wdata <= w;
         @(posedge i_clk);
         i_wr <= 1'b0;
         // A write shows in the control word for one cycle only.
         rd(hsl_pkg::ADDR_CONTROL,
            {30'h0, w[1:0] | {i_suspended, i_configured}});
         i_rd <= 1'b0;
         repeat (12)
         begin
            i_configured <= 1'($urandom);
            i_suspended <= 1'($urandom);
            @(posedge i_clk);
         end
         repeat (3) @(posedge i_clk);
         chk("ind", 32'((i_configured & ~i_suspended) ^ (en & s[0])),
            32'(ind));
         chk("ind_oe", 32'h1, 32'(oe));
      end
      finish_test();
   end
endmodule // hsl_top_bench
